// ---- rtl/msc_misc_ctrl.sv ----
// Miscellaneous system control register with AXI4-Lite access.
`timescale 1ns/1ns

module msc_misc_ctrl #(
    parameter logic WATCHDOG_ENABLE_BIT_OPTION = 1'b0
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [msc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [msc_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [msc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [msc_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Core-side inputs
    input wire logic cpu_irq_mask,
    input wire logic stop_enter,
    input wire logic watchdog_enable_bit_reset_req,
    // Pins
    input wire logic irq_pin,
    input wire logic wired_or_interrupt,
    input wire logic ext_reset_pin_n,
    // Outputs to the rest of the device
    output logic irq_request,
    output logic woi_request,
    output logic [msc_pkg::PLM_PER_W-1:0] mod_a_period,
    output logic [msc_pkg::PLM_PER_W-1:0] mod_b_period,
    output logic bus_tick,
    output logic watchdog_enable,
    output logic watchdog_clear,
    output logic irq
);
    import msc_pkg::*;

    function automatic msc_sel_t reg_sel(input logic [ADDR_W-1:0] a);
        case (a)
            OFF_MISC: reg_sel = SEL_MISC;
            OFF_EVT_STS: reg_sel = SEL_STS;
            OFF_EVT_CLR: reg_sel = SEL_CLR;
            OFF_EVT_EN: reg_sel = SEL_EN;
            default: reg_sel = SEL_NONE;
        endcase
    endfunction

    // Invert selects the wired-OR mapping, which mirrors the pin mapping.
    function automatic logic detect(input logic [1:0] mode, input logic cur,
                                    input logic prev, input logic invert);
        logic act_lvl;
        logic edge_a;
        logic edge_b;
        act_lvl = invert ? cur : ~cur;
        edge_a = invert ? (cur & ~prev) : (~cur & prev);
        edge_b = invert ? (~cur & prev) : (cur & ~prev);
        case (mode)
            SENS_LEVEL: detect = edge_a | act_lvl;
            SENS_FIRST: detect = edge_a;
            SENS_SECOND: detect = edge_b;
            default: detect = edge_a | edge_b;
        endcase
    endfunction

    msc_ctrl_t ctrl_r, ctrl_nxt;
    logic [EVT_W-1:0] sts_r, sts_nxt, en_r, en_nxt;
    logic [PIN_W-1:0] sync1_r, sync2_r;
    logic [1:0] prev_r, prev_nxt;
    msc_wr_state_t wst_r, wst_nxt;
    logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
    logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
    logic [CTRL_W-1:0] wdata_r, wdata_nxt;
    logic wstrb0_r, wstrb0_nxt;
    logic awready_r, awready_nxt, wready_r, wready_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic [DIV_W-1:0] div_r, div_nxt;
    logic tick_r, tick_nxt;
    logic irq_req_r, irq_req_nxt, woi_req_r, woi_req_nxt;
    logic wclr_r, wclr_nxt, irq_r, irq_nxt;
    logic [PLM_PER_W-1:0] per_a_r, per_a_nxt, per_b_r, per_b_nxt;
    logic ext_rst, rst_any, irq_hit, woi_hit;
    logic [1:0] mode;
    msc_sel_t wsel;
    msc_ctrl_t wfld;

    assign ext_rst = ~sync2_r[PIN_XRST];
    assign rst_any = ext_rst | watchdog_enable_bit_reset_req;
    assign mode = {ctrl_r.irq_pos_select, ctrl_r.irq_neg_select};
    assign wsel = reg_sel(awaddr_r);
    assign wfld = msc_ctrl_t'(wdata_r);

    always_comb begin
        ctrl_nxt = ctrl_r;
        sts_nxt = sts_r;
        en_nxt = en_r;
        wst_nxt = wst_r;
        aw_got_nxt = aw_got_r;
        w_got_nxt = w_got_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb0_nxt = wstrb0_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        arready_nxt = arready_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        wclr_nxt = 1'b0;
        prev_nxt = {sync2_r[PIN_WOI], sync2_r[PIN_IRQ]};

        // Address and data are taken in either order, then answered.
        if (s_axi_awvalid && awready_r) begin
            aw_got_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_r) begin
            w_got_nxt = 1'b1;
            wdata_nxt = s_axi_wdata[CTRL_W-1:0];
            wstrb0_nxt = s_axi_wstrb[0];
        end
        case (wst_r)
            WR_IDLE: begin
                if (aw_got_r && w_got_r) begin
                    aw_got_nxt = 1'b0;
                    w_got_nxt = 1'b0;
                    bvalid_nxt = 1'b1;
                    wst_nxt = WR_RESP;
                    bresp_nxt = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
                    if (wstrb0_r && wsel == SEL_MISC) begin
                        ctrl_nxt.por = ctrl_r.por & wdata_r[BIT_POR];
                        if (cpu_irq_mask) begin
                            ctrl_nxt.irq_pos_select = wfld.irq_pos_select;
                            ctrl_nxt.irq_neg_select = wfld.irq_neg_select;
                            ctrl_nxt.ext_irq_enable = wfld.ext_irq_enable;
                        end
                        ctrl_nxt.mod_a_slow_select = wfld.mod_a_slow_select;
                        ctrl_nxt.mod_b_slow_select = wfld.mod_b_slow_select;
                        ctrl_nxt.bus_slow_select = wfld.bus_slow_select;
                        if (wdata_r[BIT_WATCHDOG_ENABLE_BIT]) begin
                            ctrl_nxt.watchdog_enable_bit = 1'b1;
                            wclr_nxt = 1'b1;
                        end
                    end
                    if (wstrb0_r && wsel == SEL_CLR) begin
                        sts_nxt = sts_r & ~wdata_r[EVT_W-1:0];
                    end
                    if (wstrb0_r && wsel == SEL_EN) begin
                        en_nxt = wdata_r[EVT_W-1:0];
                    end
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    bvalid_nxt = 1'b0;
                    wst_nxt = WR_IDLE;
                end
            end
            default: wst_nxt = WR_IDLE;
        endcase
        awready_nxt = (wst_nxt == WR_IDLE) && !aw_got_nxt;
        wready_nxt = (wst_nxt == WR_IDLE) && !w_got_nxt;

        if (s_axi_arvalid && arready_r) begin
            arready_nxt = 1'b0;
            rvalid_nxt = 1'b1;
            rresp_nxt = RESP_OKAY;
            case (reg_sel(s_axi_araddr))
                SEL_MISC: rdata_nxt = {{(DATA_W-CTRL_W){1'b0}}, ctrl_r};
                SEL_STS: rdata_nxt = {{(DATA_W-EVT_W){1'b0}}, sts_r};
                SEL_EN: rdata_nxt = {{(DATA_W-EVT_W){1'b0}}, en_r};
                SEL_CLR: rdata_nxt = '0;
                default: begin
                    rdata_nxt = '0;
                    rresp_nxt = RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
            arready_nxt = 1'b1;
        end

        // Stop wins over a write in the same cycle.
        if (stop_enter) begin
            ctrl_nxt.bus_slow_select = 1'b0;
        end
        // Pin or watchdog reset: everything but the power-on flag.
        if (rst_any) begin
            ctrl_nxt.irq_pos_select = 1'b0;
            ctrl_nxt.irq_neg_select = 1'b0;
            ctrl_nxt.ext_irq_enable = 1'b1;
            ctrl_nxt.mod_a_slow_select = 1'b0;
            ctrl_nxt.mod_b_slow_select = 1'b0;
            ctrl_nxt.bus_slow_select = 1'b0;
            ctrl_nxt.watchdog_enable_bit = WATCHDOG_ENABLE_BIT_OPTION;
        end

        // Events set after the clear, so a set in the same cycle survives.
        irq_hit = ctrl_r.ext_irq_enable
            & detect(mode, sync2_r[PIN_IRQ], prev_r[0], 1'b0);
        woi_hit = detect(mode, sync2_r[PIN_WOI], prev_r[1], 1'b1);
        irq_req_nxt = irq_hit;
        woi_req_nxt = woi_hit;
        sts_nxt[EVT_IRQ] = sts_nxt[EVT_IRQ] | irq_hit;
        sts_nxt[EVT_WOI] = sts_nxt[EVT_WOI] | woi_hit;
        irq_nxt = |(sts_nxt & en_nxt);

        // The selects act at once; no shadow copy is kept.
        per_a_nxt = ctrl_r.mod_a_slow_select ? PLM_SLOW_PERIOD
                                             : PLM_FAST_PERIOD;
        per_b_nxt = ctrl_r.mod_b_slow_select ? PLM_SLOW_PERIOD
                                             : PLM_FAST_PERIOD;
        div_nxt = ctrl_r.bus_slow_select ? div_r + 1'b1 : '0;
        tick_nxt = !ctrl_r.bus_slow_select || (div_r == SLOW_DIV_LAST);
    end

    // Pins pass two flip-flops before any logic reads them.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // Idle levels, so leaving reset fakes no wired-OR level or edge.
            sync1_r <= PIN_IDLE;
            sync2_r <= PIN_IDLE;
        end else begin
            sync1_r <= {ext_reset_pin_n, wired_or_interrupt, irq_pin};
            sync2_r <= sync1_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= {CTRL_POR_VAL[CTRL_W-1:1], WATCHDOG_ENABLE_BIT_OPTION};
            sts_r <= '0;
            en_r <= '0;
            prev_r <= {PIN_IDLE[PIN_WOI], PIN_IDLE[PIN_IRQ]};
            wst_r <= WR_IDLE;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb0_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
            div_r <= '0;
            tick_r <= 1'b1;
            irq_req_r <= 1'b0;
            woi_req_r <= 1'b0;
            wclr_r <= 1'b0;
            irq_r <= 1'b0;
            per_a_r <= PLM_FAST_PERIOD;
            per_b_r <= PLM_FAST_PERIOD;
        end else begin
            ctrl_r <= ctrl_nxt;
            sts_r <= sts_nxt;
            en_r <= en_nxt;
            prev_r <= prev_nxt;
            wst_r <= wst_nxt;
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb0_r <= wstrb0_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            div_r <= div_nxt;
            tick_r <= tick_nxt;
            irq_req_r <= irq_req_nxt;
            woi_req_r <= woi_req_nxt;
            wclr_r <= wclr_nxt;
            irq_r <= irq_nxt;
            per_a_r <= per_a_nxt;
            per_b_r <= per_b_nxt;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign irq_request = irq_req_r;
    assign woi_request = woi_req_r;
    assign mod_a_period = per_a_r;
    assign mod_b_period = per_b_r;
    assign bus_tick = tick_r;
    assign watchdog_enable = ctrl_r.watchdog_enable_bit;
    assign watchdog_clear = wclr_r;
    assign irq = irq_r;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_rise_seen;
        ctrl_r.ext_irq_enable && mode == SENS_SECOND
            && sync2_r[PIN_IRQ] && !prev_r[0];
    endsequence
    sequence s_tick_slow;
        tick_r && ctrl_r.bus_slow_select;
    endsequence

    property p_por_no_set;
        !ctrl_r.por |=> !ctrl_r.por;
    endproperty
    a_por_no_set: assert property (p_por_no_set)
        else $error("power-on flag set without power-on");
    property p_sens_gate;
        (!cpu_irq_mask && !rst_any) |=>
            $stable({ctrl_r.irq_pos_select, ctrl_r.irq_neg_select});
    endproperty
    a_sens_gate: assert property (p_sens_gate)
        else $error("sensitivity changed while mask clear");
    property p_irq_rise;
        s_rise_seen |=> irq_request;
    endproperty
    a_irq_rise: assert property (p_irq_rise)
        else $error("rising pin edge missed");
    property p_woi_level;
        (mode == SENS_LEVEL && sync2_r[PIN_WOI]) |=> woi_request;
    endproperty
    a_woi_level: assert property (p_woi_level)
        else $error("wired-or high level missed");
    property p_irq_off;
        !ctrl_r.ext_irq_enable |=> !irq_request;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("pin request while disabled");
    property p_ext_irq_enable_gate;
        (!cpu_irq_mask && !rst_any) |=> $stable(ctrl_r.ext_irq_enable);
    endproperty
    a_ext_irq_enable_gate: assert property (p_ext_irq_enable_gate)
        else $error("enable changed while mask clear");
    property p_per_a;
        ctrl_r.mod_a_slow_select |=> mod_a_period == PLM_SLOW_PERIOD;
    endproperty
    a_per_a: assert property (p_per_a)
        else $error("modulator A slow period wrong");
    property p_per_b;
        !ctrl_r.mod_b_slow_select |=> mod_b_period == PLM_FAST_PERIOD;
    endproperty
    a_per_b: assert property (p_per_b)
        else $error("modulator B fast period wrong");
    property p_slow_tick;
        s_tick_slow ##1 ctrl_r.bus_slow_select |-> !tick_r;
    endproperty
    a_slow_tick: assert property (p_slow_tick)
        else $error("slow bus tick came too soon");
    property p_stop_clr;
        stop_enter |=> !ctrl_r.bus_slow_select;
    endproperty
    a_stop_clr: assert property (p_stop_clr)
        else $error("slow mode survived stop");
    property p_watchdog_enable_bit_keep;
        (ctrl_r.watchdog_enable_bit && !rst_any)
            |=> ctrl_r.watchdog_enable_bit;
    endproperty
    a_watchdog_enable_bit_keep: assert property (p_watchdog_enable_bit_keep)
        else $error("watchdog disabled by software");
    property p_watchdog_enable_bit_rst;
        rst_any |=> ctrl_r.watchdog_enable_bit == WATCHDOG_ENABLE_BIT_OPTION;
    endproperty
    a_watchdog_enable_bit_rst: assert property (p_watchdog_enable_bit_rst)
        else $error("watchdog bit not from option");
endmodule

// ---- rtl/msc_pkg.sv ----
// Shared constants and types of the miscellaneous system control block.
package msc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Byte addresses of the registers.
    localparam logic [ADDR_W-1:0] OFF_MISC = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_EVT_STS = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_EVT_CLR = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_EVT_EN = 8'h18;

    // Control register layout, bit 7 down to bit 0.
    typedef struct packed {
        logic por;
        logic irq_pos_select;
        logic irq_neg_select;
        logic ext_irq_enable;
        logic mod_a_slow_select;
        logic mod_b_slow_select;
        logic bus_slow_select;
        logic watchdog_enable_bit;
    } msc_ctrl_t;

    localparam int CTRL_W = 8;
    localparam int BIT_POR = 7;
    localparam int BIT_WATCHDOG_ENABLE_BIT = 0;
    // Power-on value without the watchdog bit: flag set, pin enabled.
    localparam logic [CTRL_W-1:0] CTRL_POR_VAL = 8'h90;

    // Event bits of the interrupt status, clear and enable registers.
    localparam int EVT_W = 2;
    localparam int EVT_IRQ = 0;
    localparam int EVT_WOI = 1;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Sensitivity codes {irq_pos_select, irq_neg_select}.
    localparam logic [1:0] SENS_LEVEL = 2'h0;
    localparam logic [1:0] SENS_FIRST = 2'h1;
    localparam logic [1:0] SENS_SECOND = 2'h2;

    localparam int PLM_PER_W = 13;
    localparam logic [PLM_PER_W-1:0] PLM_SLOW_PERIOD = 13'h1000;
    localparam logic [PLM_PER_W-1:0] PLM_FAST_PERIOD = 13'h0100;

    localparam int DIV_W = 4;
    localparam logic [DIV_W-1:0] SLOW_DIV_LAST = 4'hf;

    // Pin synchroniser lanes.
    localparam int PIN_W = 3;
    localparam int PIN_IRQ = 0;
    localparam int PIN_WOI = 1;
    localparam int PIN_XRST = 2;
    // Idle level of each lane: reset pin high, wired-OR low, pin high.
    localparam logic [PIN_W-1:0] PIN_IDLE = 3'h5;

    typedef enum logic [2:0] {
        SEL_MISC = 3'h0,
        SEL_STS = 3'h1,
        SEL_CLR = 3'h2,
        SEL_EN = 3'h3,
        SEL_NONE = 3'h4
    } msc_sel_t;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } msc_wr_state_t;
endpackage

// ---- bench/tb.sv ----
// Self-checking testbench for the miscellaneous system control block.
`timescale 1ns/1ns
module tb;
    import msc_pkg::*;
    logic aclk, aresetn;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic cpu_irq_mask, stop_enter, watchdog_enable_bit_reset_req;
    logic irq_pin, wired_or_interrupt, ext_reset_pin_n;
    logic irq_request, woi_request, bus_tick;
    logic watchdog_enable, watchdog_clear, irq;
    logic [PLM_PER_W-1:0] mod_a_period, mod_b_period;
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;
    int n_wclr = 0;
    int n_irqr = 0;
    int n_woir = 0;

    msc_misc_ctrl dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .cpu_irq_mask(cpu_irq_mask),
        .stop_enter(stop_enter), .watchdog_enable_bit_reset_req(watchdog_enable_bit_reset_req),
        .irq_pin(irq_pin), .wired_or_interrupt(wired_or_interrupt),
        .ext_reset_pin_n(ext_reset_pin_n), .irq_request(irq_request),
        .woi_request(woi_request), .mod_a_period(mod_a_period),
        .mod_b_period(mod_b_period), .bus_tick(bus_tick),
        .watchdog_enable(watchdog_enable),
        .watchdog_clear(watchdog_clear), .irq(irq));

    always #50 aclk = ~aclk;

    task automatic wrap_up();
        if (n_fail == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // The run is a few hundred cycles; the ceiling leaves a wide margin.
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            wrap_up();
        end
    end

    // Pulses are counted between edges, where the outputs have settled.
    always @(negedge aclk) begin
        if (watchdog_clear === 1'h1) n_wclr++;
        if (irq_request === 1'h1) n_irqr++;
        if (woi_request === 1'h1) n_woir++;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED at %0t: got %h expected %h",
                $time, got, exp);
            n_fail++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] s = 4'hf, input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'h1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        check({30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
            input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
        check(s_axi_rdata, exp);
        check({30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    task automatic periods(input logic [PLM_PER_W-1:0] p);
        check({19'h0, mod_a_period}, {19'h0, p});
        check({19'h0, mod_b_period}, {19'h0, p});
    endtask

    // Counting over 32 cycles gives an exact figure whatever the phase.
    task automatic ticks(input int exp);
        int k;
        k = 0;
        repeat (32) begin
            @(posedge aclk);
            if (bus_tick === 1'h1) k++;
        end
        check(k, exp);
    endtask

    task automatic t_reset();
        rd(OFF_MISC, 32'h90);
        check({31'h0, watchdog_enable}, 32'h0);
        periods(PLM_FAST_PERIOD);
        rd(OFF_EVT_STS, 32'h0);
        rd(8'h40, 32'h0, RESP_SLVERR);
        wr(8'h40, 32'hff, 4'hf, RESP_SLVERR);
        wr(OFF_MISC, 32'h0e, 4'he);
        rd(OFF_MISC, 32'h90);
    endtask

    task automatic t_gating();
        int w0;
        w0 = n_wclr;
        cpu_irq_mask <= 1'h0;
        wr(OFF_MISC, 32'hff);
        rd(OFF_MISC, 32'h9f);
        check(n_wclr - w0, 1);
        check({31'h0, watchdog_enable}, 32'h1);
        periods(PLM_SLOW_PERIOD);
        ticks(2);
        cpu_irq_mask <= 1'h1;
        wr(OFF_MISC, 32'h60);
        rd(OFF_MISC, 32'h61);
        check(n_wclr - w0, 1);
        periods(PLM_FAST_PERIOD);
        ticks(32);
    endtask

    task automatic t_resets();
        int w0;
        w0 = n_wclr;
        cpu_irq_mask <= 1'h0;
        wr(OFF_MISC, 32'h02);
        rd(OFF_MISC, 32'h63);
        stop_enter <= 1'h1;
        @(posedge aclk);
        stop_enter <= 1'h0;
        rd(OFF_MISC, 32'h61);
        wr(OFF_MISC, 32'h0e);
        ext_reset_pin_n <= 1'h0;
        repeat (3) @(posedge aclk);
        ext_reset_pin_n <= 1'h1;
        repeat (4) @(posedge aclk);
        rd(OFF_MISC, 32'h10);
        check({31'h0, watchdog_enable}, 32'h0);
        cpu_irq_mask <= 1'h1;
        wr(OFF_MISC, 32'h6f);
        rd(OFF_MISC, 32'h6f);
        check(n_wclr - w0, 1);
        watchdog_enable_bit_reset_req <= 1'h1;
        @(posedge aclk);
        watchdog_enable_bit_reset_req <= 1'h0;
        rd(OFF_MISC, 32'h10);
    endtask

    // Pin idles high and the wired-OR line low, so no level mode fires.
    task automatic t_sense();
        logic [1:0] c;
        logic en, f, r;
        int n0, m0;
        cpu_irq_mask <= 1'h1;
        for (int i = 0; i < 5; i++) begin
            c = (i < 4) ? i[1:0] : 2'h1;
            en = (i < 4);
            f = (c != 2'h2);
            r = c[1] | (c == 2'h0);
            wr(OFF_MISC, {25'h0, c, en, 4'h0});
            wr(OFF_EVT_CLR, 32'h3);
            rd(OFF_EVT_STS, 32'h0);
            n0 = n_irqr;
            m0 = n_woir;
            irq_pin <= 1'h0;
            wired_or_interrupt <= 1'h1;
            repeat (5) @(posedge aclk);
            rd(OFF_EVT_STS, {30'h0, f, en & f});
            check(n_irqr != n0, en & f);
            check(n_woir != m0, f);
            wr(OFF_EVT_CLR, 32'h3);
            n0 = n_irqr;
            m0 = n_woir;
            irq_pin <= 1'h1;
            wired_or_interrupt <= 1'h0;
            repeat (5) @(posedge aclk);
            rd(OFF_EVT_STS, {30'h0, r, en & r});
            check(n_irqr != n0, en & r);
            check(n_woir != m0, r);
            wr(OFF_EVT_CLR, 32'h3);
        end
    endtask

    task automatic t_irq();
        wr(OFF_MISC, 32'h30);
        wr(OFF_EVT_CLR, 32'h3);
        irq_pin <= 1'h0;
        repeat (5) @(posedge aclk);
        check({31'h0, irq}, 32'h0);
        wr(OFF_EVT_EN, 32'h2);
        check({31'h0, irq}, 32'h0);
        wr(OFF_EVT_EN, 32'h1);
        repeat (2) @(posedge aclk);
        check({31'h0, irq}, 32'h1);
        rd(OFF_EVT_EN, 32'h1);
        irq_pin <= 1'h1;
        wr(OFF_EVT_CLR, 32'h1);
        repeat (2) @(posedge aclk);
        check({31'h0, irq}, 32'h0);
        rd(OFF_EVT_CLR, 32'h0);
    endtask

    initial begin
        aclk = 1'h0;
        aresetn = 1'h0;
        s_axi_awaddr = 8'h0;
        s_axi_awvalid = 1'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'h0;
        s_axi_bready = 1'h0;
        s_axi_araddr = 8'h0;
        s_axi_arvalid = 1'h0;
        s_axi_rready = 1'h0;
        cpu_irq_mask = 1'h0;
        stop_enter = 1'h0;
        watchdog_enable_bit_reset_req = 1'h0;
        irq_pin = 1'h1;
        wired_or_interrupt = 1'h0;
        ext_reset_pin_n = 1'h1;
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset();
        t_gating();
        t_resets();
        t_sense();
        t_irq();
        wrap_up();
    end
endmodule
